// file: rtl/fbs_tap.v
`timescale 1ns/1ps
`default_nettype none
`include "fbs_map.vh"

module fbs_tap #(
    parameter [10:0] MAKER_CODE = 11'h155, // Arbitrary value
    parameter [15:0] PART_CODE = 16'h1234, // Arbitrary value
    parameter [3:0] VERSION_CODE = 4'h1 // Arbitrary value
) (
    input wire clk_sys, // System clock, 100 MHz
    input wire srst, // Synchronous reset, active high
    input wire tck, // Test clock pin
    input wire tms, // Test mode select pin
    input wire tdi, // Test data in pin
    input wire trst_n, // Test reset pin, active low
    output reg tdo, // Test data out
    output reg tdo_oe_n, // Low while TDO is driven
    input wire [`FBS_BSR_LEN-1:0] pin_in, // Levels seen on the pads
    input wire [`FBS_BSR_LEN-1:0] core_out, // Data the FIFO core drives
    input wire [`FBS_BSR_LEN-1:0] core_oe_n, // Core output enables, active low
    output reg [`FBS_BSR_LEN-1:0] pin_out, // Data to the pads
    output reg [`FBS_BSR_LEN-1:0] pin_oe_n, // Pad enables, low drives
    output wire [`FBS_IR_W-1:0] instr, // Current instruction
    output wire tap_reset // TAP is in its reset state
);

    // Every pin input passes two flops before any logic reads it
    reg [3:0] pin_m_r;
    reg [3:0] pin_s_r;
    // A pad that moves during capture must not split the chain into two snapshots
    reg [`FBS_BSR_LEN-1:0] pad_m_r;
    reg [`FBS_BSR_LEN-1:0] pad_s_r;
    reg tck_d_r;
    wire tck_s;
    wire tms_s;
    wire tdi_s;
    wire trst_n_s;
    wire tck_rise;
    wire tck_fall;

    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            pin_m_r <= 4'h8;
            pin_s_r <= 4'h8;
            pad_m_r <= {`FBS_BSR_LEN{1'b0}};
            pad_s_r <= {`FBS_BSR_LEN{1'b0}};
            tck_d_r <= 1'b0;
        end
        else
        begin
            pin_m_r <= {trst_n, tdi, tms, tck};
            pin_s_r <= pin_m_r;
            pad_m_r <= pin_in;
            pad_s_r <= pad_m_r;
            tck_d_r <= tck_s;
        end
    end

    assign tck_s = pin_s_r[0];
    assign tms_s = pin_s_r[1];
    assign tdi_s = pin_s_r[2];
    assign trst_n_s = pin_s_r[3];
    assign tck_rise = tck_s & ~tck_d_r;
    assign tck_fall = ~tck_s & tck_d_r;

    wire [3:0] state_r;
    wire [3:0] state_nxt;

    // The controller moves only on system reset, test reset or TMS sequences
    fbs_tap_fsm u_fsm (
        .clk_sys(clk_sys),
        .srst(srst),
        .trst_n_s(trst_n_s),
        .tck_rise(tck_rise),
        .tms_s(tms_s),
        .state_r(state_r),
        .state_nxt(state_nxt)
    );

    // Action strobes, one system cycle each, at the test clock rise
    wire cap_dr = tck_rise && (state_r == `FBS_ST_CAP_DR);
    wire sh_dr = tck_rise && (state_r == `FBS_ST_SH_DR);
    wire upd_dr = tck_rise && (state_nxt == `FBS_ST_UPD_DR) && (state_r != `FBS_ST_UPD_DR);
    wire cap_ir = tck_rise && (state_r == `FBS_ST_CAP_IR);
    wire sh_ir = tck_rise && (state_r == `FBS_ST_SH_IR);
    wire upd_ir = tck_rise && (state_nxt == `FBS_ST_UPD_IR) && (state_r != `FBS_ST_UPD_IR);

    // Instruction register: shift stage and latched current instruction
    reg [`FBS_IR_W-1:0] ir_sh_r;
    reg [`FBS_IR_W-1:0] ir_r;
    reg [`FBS_IR_W-1:0] ir_sh_nxt;
    reg [`FBS_IR_W-1:0] ir_nxt;

    always @*
    begin
        ir_sh_nxt = ir_sh_r;
        ir_nxt = ir_r;
        if (cap_ir)
            ir_sh_nxt = `FBS_IR_CAPTURE;
        else if (sh_ir)
            ir_sh_nxt = {tdi_s, ir_sh_r[`FBS_IR_W-1:1]};
        // Only the update strobe moves the code, so a half-shifted code never decodes
        if (upd_ir)
            ir_nxt = ir_sh_r;
    end

    always @(posedge clk_sys)
    begin
        // Reset state reloads the identity code, so a fresh TAP reads its identity first
        if (srst || !trst_n_s || state_r == `FBS_ST_RESET)
        begin
            ir_sh_r <= `FBS_IR_IDCODE;
            ir_r <= `FBS_IR_IDCODE;
        end
        else
        begin
            ir_sh_r <= ir_sh_nxt;
            ir_r <= ir_nxt;
        end
    end

    assign instr = ir_r;
    assign tap_reset = (state_r == `FBS_ST_RESET);

    // Instruction decode; anything unassigned falls to bypass
    reg sel_bsr;
    reg sel_id;
    reg sel_byp;
    reg mode_extest;
    reg mode_float;

    always @*
    begin
        sel_bsr = 1'b0;
        sel_id = 1'b0;
        sel_byp = 1'b0;
        mode_extest = 1'b0;
        mode_float = 1'b0;
        case (ir_r)
            `FBS_IR_EXTEST:
            begin
                sel_bsr = 1'b1;
                mode_extest = 1'b1;
            end
            `FBS_IR_SAMPLE: sel_bsr = 1'b1;
            `FBS_IR_IDCODE: sel_id = 1'b1;
            `FBS_IR_FLOAT:
            begin
                // Pads float, yet the serial path stays one stage long
                sel_byp = 1'b1;
                mode_float = 1'b1;
            end
            `FBS_IR_BYPASS: sel_byp = 1'b1;
            default: sel_byp = 1'b1;
        endcase
    end

    // Exactly one select is high, so one register sits between TDI and TDO

    // Bypass: one stage that captures zero
    reg byp_r;
    reg byp_nxt;

    always @*
    begin
        byp_nxt = byp_r;
        if (sel_byp && cap_dr)
            byp_nxt = 1'b0;
        else if (sel_byp && sh_dr)
            byp_nxt = tdi_s;
    end

    always @(posedge clk_sys)
    begin
        if (srst)
            byp_r <= 1'b0;
        else
            byp_r <= byp_nxt;
    end

    // Identity register is read only: capture reloads it, shift moves TDI in at the top as it drains
    wire [`FBS_ID_W-1:0] id_value;
    reg [`FBS_ID_W-1:0] id_sh_r;
    reg [`FBS_ID_W-1:0] id_sh_nxt;

    assign id_value[0] = 1'b1;
    assign id_value[`FBS_ID_MAKER_MSB:`FBS_ID_MAKER_LSB] = MAKER_CODE;
    assign id_value[`FBS_ID_PART_MSB:`FBS_ID_PART_LSB] = PART_CODE;
    assign id_value[`FBS_ID_VER_MSB:`FBS_ID_VER_LSB] = VERSION_CODE;

    always @*
    begin
        id_sh_nxt = id_sh_r;
        if (sel_id && cap_dr)
            id_sh_nxt = id_value;
        else if (sel_id && sh_dr)
            id_sh_nxt = {tdi_s, id_sh_r[`FBS_ID_W-1:1]};
    end

    always @(posedge clk_sys)
    begin
        if (srst)
            id_sh_r <= {`FBS_ID_W{1'b0}};
        else
            id_sh_r <= id_sh_nxt;
    end

    // Boundary scan: shift chain and parallel update latches
    reg [`FBS_BSR_LEN-1:0] bsr_sh_r;
    reg [`FBS_BSR_LEN-1:0] bsr_upd_r;
    reg [`FBS_BSR_LEN-1:0] bsr_sh_nxt;
    reg [`FBS_BSR_LEN-1:0] bsr_upd_nxt;

    always @*
    begin
        bsr_sh_nxt = bsr_sh_r;
        bsr_upd_nxt = bsr_upd_r;
        if (sel_bsr && cap_dr)
            bsr_sh_nxt = pad_s_r;
        else if (sel_bsr && sh_dr)
            bsr_sh_nxt = {tdi_s, bsr_sh_r[`FBS_BSR_LEN-1:1]};
        // Exit and pause states fall through and hold
        if (sel_bsr && upd_dr)
            bsr_upd_nxt = bsr_sh_r;
    end

    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            bsr_sh_r <= {`FBS_BSR_LEN{1'b0}};
            bsr_upd_r <= {`FBS_BSR_LEN{1'b0}};
        end
        else
        begin
            bsr_sh_r <= bsr_sh_nxt;
            bsr_upd_r <= bsr_upd_nxt;
        end
    end

    // Pad muxing: core owns the pads except under the test and float codes.
    // Registered, so pads lag the mode by one system cycle.
    genvar gi;
    generate
        for (gi = 0; gi < `FBS_BSR_LEN; gi = gi + 1)
        begin : g_pad
            always @(posedge clk_sys)
            begin
                if (srst)
                begin
                    pin_out[gi] <= 1'b0;
                    pin_oe_n[gi] <= 1'b1;
                end
                else if (mode_float)
                begin
                    pin_out[gi] <= core_out[gi];
                    pin_oe_n[gi] <= 1'b1;
                end
                else if (mode_extest)
                begin
                    pin_out[gi] <= bsr_upd_r[gi];
                    pin_oe_n[gi] <= 1'b0;
                end
                else
                begin
                    pin_out[gi] <= core_out[gi];
                    pin_oe_n[gi] <= core_oe_n[gi];
                end
            end
        end
    endgenerate

    // Serial output: LSB of the selected path, moved on the test clock fall
    reg tdo_nxt;
    wire in_shift = (state_r == `FBS_ST_SH_DR) || (state_r == `FBS_ST_SH_IR);

    always @*
    begin
        if (state_r == `FBS_ST_SH_IR)
            tdo_nxt = ir_sh_r[0];
        else if (sel_id)
            tdo_nxt = id_sh_r[0];
        else if (sel_bsr)
            tdo_nxt = bsr_sh_r[0];
        else
            tdo_nxt = byp_r;
    end

    // Moving TDO on the fall gives the tester half a period of setup before it samples
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
        end
        else if (tck_fall)
        begin
            tdo <= tdo_nxt;
            tdo_oe_n <= ~in_shift;
        end
    end

endmodule // fbs_tap

`default_nettype wire

// file: shared/fbs_map.vh
// Functional notes
// - TAP never self-resets; tester must reset it
// - Five TMS-high test clocks reach reset state
// - States advance on test clock rise, TMS
// - Capture-DR loads selected register in parallel
// - Shift LSB first; TDO changes on fall
// - Update-DR moves shifted data to latches
// - Exit plus TMS high goes to Update
// - Pause-DR holds all selected registers
// - IR branch mirrors DR branch on IR
// - Instruction takes effect at Update-IR only
// - Four-bit IR, LSB nearest serial output
// - Data registers parallel, instruction selects one
// - Bypass one stage, captures zero
// - Bypass leaves FIFO operation untouched
// - ID: bit0 one, maker, part, version
// - Code 0x00: boundary cells drive pins
// - Code 0x01: sample pins, preload latches
// - Code 0x02: identity register in path
// - Code 0x03: all output pins float
// - Code 0x0F: single-stage bypass in path
`ifndef FBS_MAP_VH
`define FBS_MAP_VH

`define FBS_ST_RESET 4'h0
`define FBS_ST_IDLE 4'h1
`define FBS_ST_SEL_DR 4'h2
`define FBS_ST_CAP_DR 4'h3
`define FBS_ST_SH_DR 4'h4
`define FBS_ST_EX1_DR 4'h5
`define FBS_ST_PAU_DR 4'h6
`define FBS_ST_EX2_DR 4'h7
`define FBS_ST_UPD_DR 4'h8
`define FBS_ST_SEL_IR 4'h9
`define FBS_ST_CAP_IR 4'ha
`define FBS_ST_SH_IR 4'hb
`define FBS_ST_EX1_IR 4'hc
`define FBS_ST_PAU_IR 4'hd
`define FBS_ST_EX2_IR 4'he
`define FBS_ST_UPD_IR 4'hf

`define FBS_IR_W 4
`define FBS_IR_EXTEST 4'h0
`define FBS_IR_SAMPLE 4'h1
`define FBS_IR_IDCODE 4'h2
`define FBS_IR_FLOAT 4'h3
`define FBS_IR_BYPASS 4'hf
`define FBS_IR_CAPTURE 4'h1

`define FBS_ID_W 32
`define FBS_ID_MAKER_LSB 1
`define FBS_ID_MAKER_MSB 11
`define FBS_ID_PART_LSB 12
`define FBS_ID_PART_MSB 27
`define FBS_ID_VER_LSB 28
`define FBS_ID_VER_MSB 31

`define FBS_BSR_LEN 8

`endif

// file: rtl/fbs_tap_fsm.v
`timescale 1ns/1ps
`default_nettype none
`include "fbs_map.vh"

module fbs_tap_fsm (
    input wire clk_sys, // System clock
    input wire srst, // Synchronous reset, active high
    input wire trst_n_s, // Synchronised test reset, active low
    input wire tck_rise, // One-cycle pulse at test clock rise
    input wire tms_s, // Synchronised mode select
    output reg [3:0] state_r, // Current TAP state
    output reg [3:0] state_nxt // State taken at next test clock rise
);

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            `FBS_ST_RESET: state_nxt = tms_s ? `FBS_ST_RESET : `FBS_ST_IDLE;
            `FBS_ST_IDLE: state_nxt = tms_s ? `FBS_ST_SEL_DR : `FBS_ST_IDLE;
            `FBS_ST_SEL_DR: state_nxt = tms_s ? `FBS_ST_SEL_IR : `FBS_ST_CAP_DR;
            `FBS_ST_CAP_DR: state_nxt = tms_s ? `FBS_ST_EX1_DR : `FBS_ST_SH_DR;
            `FBS_ST_SH_DR: state_nxt = tms_s ? `FBS_ST_EX1_DR : `FBS_ST_SH_DR;
            `FBS_ST_EX1_DR: state_nxt = tms_s ? `FBS_ST_UPD_DR : `FBS_ST_PAU_DR;
            `FBS_ST_PAU_DR: state_nxt = tms_s ? `FBS_ST_EX2_DR : `FBS_ST_PAU_DR;
            `FBS_ST_EX2_DR: state_nxt = tms_s ? `FBS_ST_UPD_DR : `FBS_ST_SH_DR;
            `FBS_ST_UPD_DR: state_nxt = tms_s ? `FBS_ST_SEL_DR : `FBS_ST_IDLE;
            `FBS_ST_SEL_IR: state_nxt = tms_s ? `FBS_ST_RESET : `FBS_ST_CAP_IR;
            `FBS_ST_CAP_IR: state_nxt = tms_s ? `FBS_ST_EX1_IR : `FBS_ST_SH_IR;
            `FBS_ST_SH_IR: state_nxt = tms_s ? `FBS_ST_EX1_IR : `FBS_ST_SH_IR;
            `FBS_ST_EX1_IR: state_nxt = tms_s ? `FBS_ST_UPD_IR : `FBS_ST_PAU_IR;
            `FBS_ST_PAU_IR: state_nxt = tms_s ? `FBS_ST_EX2_IR : `FBS_ST_PAU_IR;
            `FBS_ST_EX2_IR: state_nxt = tms_s ? `FBS_ST_UPD_IR : `FBS_ST_SH_IR;
            `FBS_ST_UPD_IR: state_nxt = tms_s ? `FBS_ST_SEL_DR : `FBS_ST_IDLE;
            default: state_nxt = `FBS_ST_RESET;
        endcase
    end

    // Test reset acts on its level alone, with no test clock needed
    always @(posedge clk_sys)
    begin
        if (srst || !trst_n_s)
            state_r <= `FBS_ST_RESET;
        else if (tck_rise)
            state_r <= state_nxt;
    end

endmodule // fbs_tap_fsm

`default_nettype wire

// file: test/fbs_tap_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fbs_tap_chk (
    input wire logic clk_sys, // clock
    input wire logic srst, // reset
    input wire logic tck, // test clock
    input wire logic tms, // mode
    input wire logic tdi, // data in
    input wire logic trst_n, // test reset
    input wire logic tdo, // data out
    input wire logic tdo_oe_n, // out enable
    input wire logic [7:0] pin_in, // pads
    input wire logic [7:0] core_out, // core data
    input wire logic [7:0] core_oe_n, // core enables
    input wire logic [7:0] pin_out, // pad data
    input wire logic [7:0] pin_oe_n, // pad enables
    input wire logic [3:0] instr, // instruction
    input wire logic tap_reset // reset state
);
    logic tck_r;
    logic [2:0] ones_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Rises with mode select high, saturating at five
    always @(posedge clk_sys)
    begin
        tck_r <= tck;
        if (srst)
            ones_r <= 3'd0;
        else if (tck && !tck_r)
            ones_r <= !tms ? 3'd0 : (ones_r == 3'd5 ? 3'd5 : ones_r + 3'd1);
    end
    a_reset_defaults: assert property (disable iff (1'b0)
        srst |=> tap_reset && instr == 4'h2 && tdo_oe_n && pin_oe_n == 8'hff) else $error("reset values");
    a_trst_forces: assert property (!trst_n [*5] |-> tap_reset && instr == 4'h2)
        else $error("test reset ignored");
    a_five_tms: assert property ((ones_r == 3'd5) [*5] |-> tap_reset)
        else $error("five ones no reset");
    a_instr_on_rise: assert property ($changed(instr) |-> tck || tap_reset)
        else $error("instruction changed off rise");
    a_tdo_on_fall: assert property ($changed(tdo_oe_n) || ($changed(tdo) && !tdo_oe_n) |-> !tck)
        else $error("serial out changed off fall");
    a_float_pads: assert property (instr == 4'h3 |=> pin_oe_n == 8'hff)
        else $error("pads not floating");
    a_extest_drive: assert property (instr == 4'h0 |=> pin_oe_n == 8'h00)
        else $error("pads not driven");
    a_core_follow: assert property (instr != 4'h0 && instr != 4'h3 |=>
        pin_out == $past(core_out) && pin_oe_n == $past(core_oe_n)) else $error("pads left core");
    c_float: cover property (instr == 4'h3);
    c_shift: cover property ($fell(tdo_oe_n));
    c_reset: cover property ($rose(tap_reset));
endmodule // fbs_tap_chk
bind fbs_tap fbs_tap_chk u_fbs_tap_chk (.clk_sys(clk_sys), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in), .core_out(core_out),
    .core_oe_n(core_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .instr(instr), .tap_reset(tap_reset));
`default_nettype wire

// file: test/fbs_tester.sv
`timescale 1ns/1ps
`default_nettype none
module fbs_tester (
    input wire logic clk_sys, // clock
    output logic tck, // test clock
    output logic tms, // mode
    output logic tdi, // data in
    output logic trst_n, // test reset
    input wire logic tdo, // data out
    input wire logic tdo_oe_n // data out enable, active low
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b1;
    end
    // 160 ns test clock; output sampled just before the rise
    task step(input logic m, input logic d, output logic q);
        @(negedge clk_sys);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (8) @(negedge clk_sys);
        // A released output is seen inverted, so a missing enable cannot pass
        q = tdo_oe_n ? ~tdo : tdo;
        tck = 1'b1;
        repeat (7) @(negedge clk_sys);
    endtask
    // Pauses once, for two test clocks, before bit p when p is from 1 to n-1
    task scan(input logic ir, input int n, input int p, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        step(1'b1, 1'b1, q);
        if (ir)
            step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++)
        begin
            if (i == p)
            begin
                repeat (2) step(1'b0, 1'b1, q);
                step(1'b1, 1'b1, q);
                step(1'b0, 1'b1, q);
            end
            step(i == n - 1 || i == p - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
    task trst_pulse;
        trst_n = 1'b0;
        repeat (10) @(negedge clk_sys);
        trst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask
    task tms_reset;
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
    endtask
endmodule // fbs_tester
`default_nettype wire

// file: test/fbs_tap_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (b)); end end
module fbs_tap_test;
    // Identity fields are arbitrary values
    localparam [10:0] MAKER = 11'h0ab;
    localparam [15:0] PART = 16'h2a5c;
    localparam [3:0] VER = 4'h7;
    localparam [31:0] ID_EXP = {VER, PART, MAKER, 1'b1};
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe_n, tap_reset, q;
    logic [7:0] pin_in, core_out, core_oe_n, pin_out, pin_oe_n;
    logic [3:0] instr;
    logic [31:0] r;
    int miscompares = 0;
    int samples_checked = 0;
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    fbs_tap #(.MAKER_CODE(MAKER), .PART_CODE(PART), .VERSION_CODE(VER)) u_fbs_tap (.clk_sys(clk_sys),
        .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .pin_in(pin_in), .core_out(core_out), .core_oe_n(core_oe_n), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .instr(instr), .tap_reset(tap_reset));
    fbs_tester u_fbs_tester (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n));
    task results;
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #500000;
        miscompares++;
        results();
    end
    initial
    begin
        pin_in = 8'h00;
        core_out = 8'h5a;
        core_oe_n = 8'h0f;
        repeat (12) @(negedge clk_sys);
        srst = 1'b0;
        u_fbs_tester.trst_pulse();
        `CHK(tap_reset, 1'b1)
        u_fbs_tester.step(1'b0, 1'b1, q);
        `CHK(tap_reset, 1'b0)
        u_fbs_tester.scan(1'b0, 32, 99, 32'h0, r);
        `CHK(r, ID_EXP)
        u_fbs_tester.scan(1'b0, 32, 13, 32'h0, r);
        `CHK(r, ID_EXP)
        u_fbs_tester.scan(1'b1, 4, 99, 32'hf, r);
        `CHK(r[3:0], 4'h1)
        `CHK(instr, 4'hf)
        u_fbs_tester.scan(1'b0, 8, 99, 32'ha7, r);
        `CHK(r[7:0], 8'h4e)
        u_fbs_tester.trst_pulse();
        `CHK(instr, 4'h2)
        u_fbs_tester.step(1'b0, 1'b1, q);
        for (int c = 0; c < 16; c++)
        begin
            core_out = {c[3:0], ~c[3:0]};
            core_oe_n = {~c[3:0], c[3:0]};
            u_fbs_tester.scan(1'b1, 4, 99, c, r);
            `CHK(instr, c[3:0])
            `CHK(pin_oe_n, c == 3 ? 8'hff : (c == 0 ? 8'h00 : core_oe_n))
            if (c != 0)
                `CHK(pin_out, core_out)
            if (c > 3)
            begin
                u_fbs_tester.scan(1'b0, 8, 99, 32'h96, r);
                `CHK(r[7:0], 8'h2c)
            end
        end
        pin_in = 8'hc3;
        u_fbs_tester.scan(1'b1, 4, 99, 32'h1, r);
        u_fbs_tester.scan(1'b0, 8, 99, 32'h3c, r);
        `CHK(r[7:0], 8'hc3)
        u_fbs_tester.scan(1'b1, 4, 99, 32'h0, r);
        `CHK(pin_out, 8'h3c)
        u_fbs_tester.step(1'b1, 1'b1, q);
        repeat (2) u_fbs_tester.step(1'b0, 1'b1, q);
        u_fbs_tester.tms_reset();
        `CHK(tap_reset, 1'b1)
        `CHK(instr, 4'h2)
        results();
    end
endmodule // fbs_tap_test
`default_nettype wire
